//--- rtl/vtsc_pkg.sv
// Package: register map, field layout and reset values of the reference control
package vtsc_pkg;

    // ----------------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------------
    localparam int          ADDR_W            = 4;
    localparam logic [3:0]  CONTROL_OFFSET    = 4'h0;
    localparam logic [3:0]  SETTLE_OFFSET     = 4'h1;

    // ----------------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------------
    localparam int          REF_ENABLE_BIT    = 7;
    localparam int          READY_FLAG_BIT    = 6;
    localparam int          TEMP_ENABLE_BIT   = 5;
    localparam int          TEMP_RANGE_BIT    = 4;
    localparam int          CMP_GAIN_HI       = 3;
    localparam int          CMP_GAIN_LO       = 2;
    localparam int          CNV_GAIN_HI       = 1;
    localparam int          CNV_GAIN_LO       = 0;

    // ----------------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------------
    localparam logic [7:0]  CONTROL_RESET     = 8'h00;
    localparam logic [7:0]  WRITABLE_MASK     = 8'hbf;

    // ----------------------------------------------------------------------
    // Software timing for temperature conversions
    // ----------------------------------------------------------------------
    localparam int          CLK_MHZ           = 250;
    localparam int          TEMP_ACQ_US       = 200;
    localparam int          TEMP_ACQ_CYCLES   = TEMP_ACQ_US * CLK_MHZ;

    // Gain codes of both reference outputs
    typedef enum logic [1:0]
    {
        VTSC_GAIN_OFF = 2'h0,
        VTSC_GAIN_1X  = 2'h1,
        VTSC_GAIN_2X  = 2'h2,
        VTSC_GAIN_4X  = 2'h3
    } vtsc_gain_t;

endpackage

//--- rtl/vtsc_ctrl_if.sv
// Interface: reference enable and settled level passed to the readiness logic, ready flag passed back to the register
`timescale 1ns/1ps
interface vtsc_ctrl_if;
    logic ref_enable;
    logic settled;
    logic ready;

    modport regs  (output ref_enable, output settled, input ready);
    modport ready_logic (input ref_enable, input settled, output ready);
endinterface

//--- rtl/vtsc_ready.sv
// Reference ready flag tracking
`timescale 1ns/1ps
module vtsc_ready
#(
    parameter bit ALWAYS_READY = 1'b0
)
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // Control
    vtsc_ctrl_if.ready_logic ctl
);

    logic ready_q;

    // ----------------------------------------------------------------------
    // Ready follows settling only while enabled
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            ready_q <= 1'b0;
        else
            ready_q <= ctl.ref_enable & ctl.settled; // [RQ2] [RQ11]
    end

    assign ctl.ready = ALWAYS_READY ? 1'b1 : ready_q; // [RQ3]

endmodule // vtsc_ready

//--- rtl/vtsc_top.sv
// Control register for fixed reference and temperature indicator
//
// Behaviour
// [RQ1] Bit 7 switches the fixed reference on when 1, off when 0.
// [RQ2] Read-only bit 6 reads 1 when reference usable, else 0.
// [RQ3] Standard-voltage variants always read the ready flag as 1.
// [RQ4] Bit 5 enables the temperature indicator.
// [RQ5] Bit 4 picks indicator range: 1 four drops, 0 two drops.
// [RQ6] Bits 3:2 pick comparator reference gain: 4x, 2x, 1x or off.
// [RQ7] Bits 1:0 pick converter reference gain: 4x, 2x, 1x or off.
// [RQ8] All writable bits clear on every reset; ready follows the reference.
// [RQ9] Software waits 200 us after routing indicator before converting.
// [RQ10] Software leaves 200 us between indicator conversions.
// [RQ11] Ready rises only after circuits report settled while enabled.
// [RQ12] Writes to bit 6 ignored; reads return fields plus live ready.
`timescale 1ns/1ps
module vtsc_top
#(
    parameter bit ALWAYS_READY = 1'b0
)
(
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         srst_i,
    // Register port
    input  wire logic [vtsc_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [7:0]                   wdata_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [7:0]                   rdata_o,
    // Analog side
    input  wire logic                         ref_settled_i,
    output logic                              ref_enable_o,
    output logic                              temp_indicator_enable_o,
    output logic                              temp_range_select_o,
    output vtsc_pkg::vtsc_gain_t              comparator_ref_gain_o,
    output vtsc_pkg::vtsc_gain_t              converter_ref_gain_o
);

    logic [7:0] control_q;
    logic [7:0] read_word;
    logic       settled_q;

    vtsc_ctrl_if ctl ();

    // ----------------------------------------------------------------------
    // Control register writes
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            control_q <= vtsc_pkg::CONTROL_RESET; // [RQ8]
        else if (wr_i && addr_i == vtsc_pkg::CONTROL_OFFSET)
            control_q <= wdata_i & vtsc_pkg::WRITABLE_MASK; // [RQ12]
    end

    // Settling indication is a plain level from the analog side
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            settled_q <= 1'b0;
        else
            settled_q <= ref_settled_i;
    end

    assign ctl.ref_enable = control_q[vtsc_pkg::REF_ENABLE_BIT];
    assign ctl.settled    = settled_q;

    vtsc_ready
    #(
        .ALWAYS_READY (ALWAYS_READY)
    )
    u_ready
    (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .ctl    (ctl)
    );

    // ----------------------------------------------------------------------
    // Field outputs
    // ----------------------------------------------------------------------
    assign ref_enable_o = control_q[vtsc_pkg::REF_ENABLE_BIT]; // [RQ1]
    assign temp_indicator_enable_o =
        control_q[vtsc_pkg::TEMP_ENABLE_BIT]; // [RQ4]
    assign temp_range_select_o =
        control_q[vtsc_pkg::TEMP_RANGE_BIT]; // [RQ5]
    assign comparator_ref_gain_o = vtsc_pkg::vtsc_gain_t'(
        control_q[vtsc_pkg::CMP_GAIN_HI:vtsc_pkg::CMP_GAIN_LO]); // [RQ6]
    assign converter_ref_gain_o = vtsc_pkg::vtsc_gain_t'(
        control_q[vtsc_pkg::CNV_GAIN_HI:vtsc_pkg::CNV_GAIN_LO]); // [RQ7]

    // ----------------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------------
    always_comb
    begin
        read_word = 8'h00;
        if (addr_i == vtsc_pkg::CONTROL_OFFSET)
        begin
            read_word = control_q;
            read_word[vtsc_pkg::READY_FLAG_BIT] = ctl.ready; // [RQ12]
        end
        else if (addr_i == vtsc_pkg::SETTLE_OFFSET)
            read_word = {7'h00, settled_q};
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= read_word;
        else
            rdata_o <= 8'h00;
    end

endmodule // vtsc_top

//--- testbench/vtsc_checker.sv
// Port checker for the reference control block
`timescale 1ns/1ps
module vtsc_checker (
    input wire logic                        clk_i, srst_i, wr_i, rd_i,
    input wire logic                        ref_settled_i,
    input wire logic [vtsc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0]                  wdata_i, rdata_o,
    input wire logic                        ref_enable_o,
    input wire logic                        temp_indicator_enable_o,
    input wire logic                        temp_range_select_o,
    input wire vtsc_pkg::vtsc_gain_t        comparator_ref_gain_o,
    input wire vtsc_pkg::vtsc_gain_t        converter_ref_gain_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_wr; wr_i && addr_i == '0; endsequence
    sequence s_rd; rd_i && addr_i == '0; endsequence
    property p_en; s_wr |=> ref_enable_o == $past(wdata_i[7]); endproperty
    a_en: assert property (p_en) else $error("enable");
    property p_ts; s_wr |=> temp_indicator_enable_o == $past(wdata_i[5]);
    endproperty
    a_ts: assert property (p_ts) else $error("indicator");
    property p_rg; s_wr |=> temp_range_select_o == $past(wdata_i[4]);
    endproperty
    a_rg: assert property (p_rg) else $error("range");
    property p_cg; s_wr |=> comparator_ref_gain_o == $past(wdata_i[3:2]);
    endproperty
    a_cg: assert property (p_cg) else $error("cmp gain");
    property p_ag; s_wr |=> converter_ref_gain_o == $past(wdata_i[1:0]);
    endproperty
    a_ag: assert property (p_ag) else $error("cnv gain");
    property p_rs; $fell(srst_i) |-> {ref_enable_o, temp_indicator_enable_o,
        temp_range_select_o, comparator_ref_gain_o,
        converter_ref_gain_o} == '0; endproperty
    a_rs: assert property (p_rs) else $error("reset");
    property p_nr; !ref_settled_i [*3] ##0 s_rd |=> !rdata_o[6]; endproperty
    a_nr: assert property (p_nr) else $error("early ready");
    property p_rb; s_rd |=> rdata_o[7] == ref_enable_o && rdata_o[5:0] ==
        {temp_indicator_enable_o, temp_range_select_o,
        comparator_ref_gain_o, converter_ref_gain_o}; endproperty
    a_rb: assert property (p_rb) else $error("readback");
endmodule // vtsc_checker
bind vtsc_top vtsc_checker u_chk (.*);

//--- testbench/vtsc_analog_model.sv
// Analog side model: settles a chosen number of cycles after enable
`timescale 1ns/1ps
module vtsc_analog_model (
    input  wire logic       clk_i,
    input  wire logic       ref_enable_i,
    input  wire logic [2:0] delay_i,
    output logic            settled_o
);
    logic [3:0] cnt_q;
    always_ff @(posedge clk_i)
    begin
        cnt_q <= ref_enable_i ? cnt_q + {3'h0, cnt_q != 4'hf} : 4'h0;
        settled_o <= ref_enable_i && cnt_q >= {1'b0, delay_i};
    end
endmodule // vtsc_analog_model

//--- testbench/test_vref_temp_sense_control.sv
// Random register traffic checked against a bench model
`timescale 1ns/1ps
module test_vref_temp_sense_control;
    logic clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, st;
    logic [3:0] addr_i = '0;
    logic [7:0] wdata_i = '0, rdata_o, got, v, m;
    logic [2:0] dly = '0;
    logic en_o, ts_o, rg_o;
    vtsc_pkg::vtsc_gain_t cg_o, ag_o;
    integer seed = 55955, err_total = 0, tests_run = 0, i, n;
    vtsc_top u_dut (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .ref_settled_i(st), .ref_enable_o(en_o),
        .temp_indicator_enable_o(ts_o), .temp_range_select_o(rg_o),
        .comparator_ref_gain_o(cg_o), .converter_ref_gain_o(ag_o));
    vtsc_analog_model u_ana (.clk_i, .ref_enable_i(en_o), .delay_i(dly),
        .settled_o(st));
    initial forever #2 clk_i = ~clk_i;
    task automatic chk(input logic [7:0] s, e);
        tests_run++;
        if (s !== e)
        begin
            err_total++;
            $display("mismatch at %0t: %h vs %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, r, input logic [3:0] a,
        input logic [7:0] d8);
        @(posedge clk_i);
        {wr_i, rd_i, addr_i} <= {w, r, a};
        wdata_i <= d8;
    endtask
    task automatic rd(input logic [3:0] a);
        bus(0, 1, a, 0);
        bus(0, 0, a, 0);
        #1 got = rdata_o;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        srst_i <= 0;
        for (i = 0; i < 40; i++)
        begin
            v = 8'($random(seed));
            dly <= 3'($random(seed));
            if (i == 20)
            begin
                srst_i <= 1;
                bus(0, 0, 0, 0);
                srst_i <= 0;
                rd(0);
                chk(got, 8'h00);
            end
            bus(1, 0, 0, 0);
            repeat (3) bus(0, 0, 0, 0);
            bus(1, 0, 0, v);
            m = v & 8'hbf;
            rd(0);
            chk(got, m);
            chk({en_o, 1'b0, ts_o, rg_o, cg_o, ag_o}, m);
            bus(1, 0, 5, ~v);
            rd(5);
            chk(got, 8'h00);
            // No indicator conversion is started, so no waits arise
            rd(0);
            for (n = 0; n < 20 && got[6] !== v[7]; n++)
                rd(0);
            if (n == 20)
            begin
                err_total++;
                final_report();
            end
            chk(got, m | {1'b0, v[7], 6'h0});
        end
        final_report();
    end
endmodule // test_vref_temp_sense_control
